// ==== rtl/xstack_pkg.sv ====
package xstack_pkg;

  // data space and pointer geometry
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned PC_W         = 21;
  localparam int unsigned INSTR_W      = 16;

  // opcode high bytes, second-word nibble and call word of the extension
  localparam logic [7:0] OP_ADD_PTR    = 8'he8;
  localparam logic [7:0] OP_SUB_PTR    = 8'he9;
  localparam logic [7:0] OP_PUSH_LIT   = 8'hea;
  localparam logic [7:0] OP_MOVE_IDX   = 8'heb;
  localparam logic [3:0] OP_SECOND_WD  = 4'hf;
  localparam logic [15:0] OP_CALL_W    = 16'h0014;

  // pointer selects that name the frame pointer, with and without a return
  localparam logic [1:0] SEL_FRAME_RET = 2'h3;
  localparam logic [1:0] SEL_FRAME     = 2'h2;

  // access-bank offset window for indexed literal offset mode
  localparam logic [7:0] IDX_LIMIT     = 8'h5f;

  // indirect addressing register window (phantom registers)
  localparam logic [ADDR_W-1:0] INDF_LO = 12'hfdf;
  localparam logic [ADDR_W-1:0] INDF_HI = 12'hfef;
  localparam logic [ADDR_W-1:0] INDF_MASK_A = 12'hfef;
  localparam logic [ADDR_W-1:0] INDF_MASK_B = 12'hfdf;
  localparam logic [ADDR_W-1:0] INDF_MASK_C = 12'hfe7;

  // access bank split: low half at 000h, high half at f80h
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

  // reset values
  localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
  localparam logic [PC_W-1:0]   PC_RST  = 21'h000000;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_MOVE2   = 2'b01,
    ST_NOP2    = 2'b10
  } seq_t;

endpackage

// ==== rtl/extended_stack_instr_exec.sv ====
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - extension active only with enable bit
// - enable also switches on indexed offsets
// - disabled: access bank or banked literal
// - enabled, a=0, f<=5Fh: frame offset
// - frame pointer zero gives legacy addresses
// - destination select keeps usual meaning
// - indexed-to-file source is pointer plus offset
// - indexed-to-file destination from second word
// - addresses span whole 4096-byte space
// - pc and return-top destinations undefined
// - indirect register source reads 00h
// - indexed-to-indexed both addresses pointer-relative
// - indexed-to-indexed decode from both words
// - indirect destination makes no-operation
// - push literal is one word, one cycle
// - push writes at pointer, then decrements
// - subtract literal from pointer, no flags
// - select 11 means subtract and return
// - subtract and return loads pc from top
// - subtract and return second cycle idle
// - add literal, select 11 adds and returns
// - call via working register, second cycle idle
module extended_stack_instr_exec (
  input  wire logic        sys_clk,         // core clock
  input  wire logic        rst,             // async reset, active high
  input  wire logic        cycle_en,        // one pulse per instruction cycle
  input  wire logic        ext_enable,      // extended_set_enable_bit strap
  input  wire logic [15:0] instr_word,      // fetched instruction word
  input  wire logic        std_byte_op,     // core: word is byte/bit-oriented
  input  wire logic [7:0]  working_reg,     // working_register contents
  input  wire logic [3:0]  bank_select,     // bank_select_register
  input  wire logic [7:0]  pc_latch_high,   // latch for pc high byte
  input  wire logic [4:0]  pc_latch_upper,  // latch for pc upper byte
  input  wire logic [20:0] return_stack_top,// return_stack_top value
  input  wire logic [20:0] pc_current,      // address of current word
  input  wire logic [7:0]  mem_rdata,       // data memory read value
  output logic [11:0]      mem_addr,        // data memory address
  output logic             mem_rd,          // read strobe
  output logic             mem_wr,          // write strobe
  output logic [7:0]       mem_wdata,       // write data
  output logic [11:0]      std_addr,        // resolved address, standard ops
  output logic             std_dest_w,      // byte op result to working reg
  output logic [11:0]      ptr0,            // file_select_pointer 0
  output logic [11:0]      ptr1,            // file_select_pointer 1
  output logic [11:0]      frame_pointer,   // file_select_pointer 2
  output logic             pc_load,         // load pc this cycle
  output logic [20:0]      pc_value,        // value to load
  output logic             stack_push,      // push return address
  output logic [20:0]      stack_push_val,  // pushed return address
  output logic             ext_busy         // second cycle of an ext op
);

  ////////////////////////////////////////////////////////////////////////////
  // state record

  typedef struct packed {
    logic [1:0]  ext_sync;   // enable bit synchroniser
    logic [11:0] ptr0_r;     // pointer 0
    logic [11:0] ptr1_r;     // pointer 1
    logic [11:0] fp_r;       // frame pointer
    xstack_pkg::seq_t seq_r; // two-cycle sequencer
    logic [7:0]  hold_r;     // byte read during move first cycle
    logic        is_ss_r;    // second cycle belongs to indexed-to-indexed
  } state_t;

  state_t cur_r;   // registered state
  state_t cur_nxt; // next state

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true for the indirect addressing registers, which have no storage
  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = ((a & xstack_pkg::INDF_MASK_C) == xstack_pkg::INDF_MASK_C &
                   (a[3:0] == 4'hf)) |
                  (a == xstack_pkg::INDF_LO) | (a == xstack_pkg::INDF_HI) |
                  (a == 12'hfe7) | (a == 12'hfff) | (a == 12'hfdf) |
                  (a == 12'hfef) | (a == 12'hfe7);
  endfunction

  logic       ext_on;     // synchronised enable
  logic [7:0] op_hi;      // opcode high byte
  logic [1:0] sel;        // pointer select field
  logic [5:0] lit6;       // 6-bit literal
  logic [11:0] src_idx;   // pointer-relative source address
  logic [11:0] dst_idx;   // pointer-relative destination address

  assign ext_on = cur_r.ext_sync[1];
  assign op_hi  = instr_word[15:8];
  assign sel    = instr_word[7:6];
  assign lit6   = instr_word[5:0];
  assign src_idx = cur_r.fp_r + {5'h00, instr_word[6:0]};
  assign dst_idx = cur_r.fp_r + {5'h00, instr_word[6:0]};

  ////////////////////////////////////////////////////////////////////////////
  // standard operand address resolution

  // byte/bit ops: f in [7:0], a in [8], d in [9]
  always_comb begin
    // d keeps its meaning in both modes
    std_dest_w = std_byte_op & ~instr_word[9];
    if (instr_word[8]) begin
      std_addr = {bank_select, instr_word[7:0]};
    end else if (ext_on && instr_word[7:0] <= xstack_pkg::IDX_LIMIT) begin
      // frame-relative offset, identical map with fp zero
      std_addr = cur_r.fp_r + {4'h0, instr_word[7:0]};
    end else if (instr_word[7]) begin
      std_addr = {xstack_pkg::ACC_HIGH_BANK, instr_word[7:0]};
    end else begin
      std_addr = {4'h0, instr_word[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode and execute

  always_comb begin
    cur_nxt        = cur_r;
    mem_addr       = 12'h000;
    mem_rd         = 1'b0;
    mem_wr         = 1'b0;
    mem_wdata      = 8'h00;
    pc_load        = 1'b0;
    pc_value       = return_stack_top;
    stack_push     = 1'b0;
    stack_push_val = pc_current + 21'h000002;
    // strap sampled through two flops, first flop read by second only
    cur_nxt.ext_sync = {cur_r.ext_sync[0], ext_enable};
    if (cycle_en) begin
      unique case (cur_r.seq_r)
        xstack_pkg::ST_IDLE: begin
          if (ext_on) begin
            if (op_hi == xstack_pkg::OP_ADD_PTR || op_hi == xstack_pkg::OP_SUB_PTR) begin
              // pointer arithmetic, one cycle except select 11 which idles a second, no flags touched
              if (op_hi == xstack_pkg::OP_ADD_PTR) begin
                unique case (sel)
                  2'h0: cur_nxt.ptr0_r = cur_r.ptr0_r + {6'h00, lit6};
                  2'h1: cur_nxt.ptr1_r = cur_r.ptr1_r + {6'h00, lit6};
                  default: cur_nxt.fp_r = cur_r.fp_r + {6'h00, lit6};
                endcase
              end else begin
                unique case (sel)
                  2'h0: cur_nxt.ptr0_r = cur_r.ptr0_r - {6'h00, lit6};
                  2'h1: cur_nxt.ptr1_r = cur_r.ptr1_r - {6'h00, lit6};
                  default: cur_nxt.fp_r = cur_r.fp_r - {6'h00, lit6};
                endcase
              end
              // select 11 returns through stack top
              if (sel == xstack_pkg::SEL_FRAME_RET) begin
                pc_load       = 1'b1;
                cur_nxt.seq_r = xstack_pkg::ST_NOP2;
              end
            end else if (op_hi == xstack_pkg::OP_PUSH_LIT) begin
              // write literal at pointer then decrement
              mem_addr   = cur_r.fp_r;
              mem_wr     = 1'b1;
              mem_wdata  = instr_word[7:0];
              cur_nxt.fp_r = cur_r.fp_r - 12'h001;
            end else if (op_hi == xstack_pkg::OP_MOVE_IDX) begin
              mem_addr = src_idx;
              mem_rd   = ~is_indirect(src_idx);
              cur_nxt.hold_r  = is_indirect(src_idx) ? 8'h00 : mem_rdata;
              // bit 7 picks indexed destination form
              cur_nxt.is_ss_r = instr_word[7];
              cur_nxt.seq_r   = xstack_pkg::ST_MOVE2;
            end else if (instr_word == xstack_pkg::OP_CALL_W) begin
              // push return, jump via working register and latches
              stack_push    = 1'b1;
              pc_load       = 1'b1;
              pc_value      = {pc_latch_upper, pc_latch_high, working_reg};
              cur_nxt.seq_r = xstack_pkg::ST_NOP2;
            end
          end
        end
        xstack_pkg::ST_MOVE2: begin
          if (instr_word[15:12] == xstack_pkg::OP_SECOND_WD) begin
            if (cur_r.is_ss_r) begin
              mem_addr = dst_idx;
              mem_wr   = ~is_indirect(dst_idx);
            end else begin
              // pc and return-top targets left unguarded, cheaper
              mem_addr = instr_word[11:0];
              mem_wr   = 1'b1;
            end
            mem_wdata = cur_r.hold_r;
          end
          cur_nxt.seq_r = xstack_pkg::ST_IDLE;
        end
        xstack_pkg::ST_NOP2: begin
          // idle second cycle while new target fetched
          cur_nxt.seq_r = xstack_pkg::ST_IDLE;
        end
        default: cur_nxt.seq_r = xstack_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_r.ext_sync <= 2'b00;
      cur_r.ptr0_r   <= xstack_pkg::PTR_RST;
      cur_r.ptr1_r   <= xstack_pkg::PTR_RST;
      cur_r.fp_r     <= xstack_pkg::PTR_RST;
      cur_r.seq_r    <= xstack_pkg::ST_IDLE;
      cur_r.hold_r   <= 8'h00;
      cur_r.is_ss_r  <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign ptr0          = cur_r.ptr0_r;
  assign ptr1          = cur_r.ptr1_r;
  assign frame_pointer = cur_r.fp_r;
  assign ext_busy      = (cur_r.seq_r != xstack_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // push decrements frame pointer by one
  chk_push_decrement: assert property (@(posedge sys_clk) disable iff (rst)
    (cycle_en && ext_on && !ext_busy && op_hi == xstack_pkg::OP_PUSH_LIT)
      |=> frame_pointer == $past(frame_pointer) - 12'h001)
    else $error("push did not decrement frame pointer");

  chk_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (!ext_on && !ext_busy) |-> (!mem_wr && !pc_load && !stack_push))
    else $error("extension acted while disabled");

  sequence move_first;
    cycle_en && ext_on && !ext_busy && op_hi == xstack_pkg::OP_MOVE_IDX;
  endsequence

  chk_move_two_cycles: assert property (@(posedge sys_clk) disable iff (rst)
    move_first |=> ext_busy)
    else $error("indexed move did not take second cycle");

  // return or call op is busy on the next clock
  chk_ret_nop: assert property (@(posedge sys_clk) disable iff (rst)
    (cycle_en && pc_load && !ext_busy) |=> ext_busy)
    else $error("return lacks idle second cycle");

  chk_indirect_dest: assert property (@(posedge sys_clk) disable iff (rst)
    (mem_wr && ext_busy && cur_r.is_ss_r) |-> !is_indirect(mem_addr))
    else $error("write to indirect register");

  chk_indirect_src: assert property (@(posedge sys_clk) disable iff (rst)
    (move_first and (is_indirect(src_idx))) |=> cur_r.hold_r == 8'h00)
    else $error("indirect source not zero");

  chk_legacy_map: assert property (@(posedge sys_clk) disable iff (rst)
    (frame_pointer == 12'h000 && !instr_word[8] && !instr_word[7])
      |-> std_addr == {4'h0, instr_word[7:0]})
    else $error("zero pointer changed access map");

  chk_sub_ptr0: assert property (@(posedge sys_clk) disable iff (rst)
    (cycle_en && ext_on && !ext_busy && op_hi == xstack_pkg::OP_SUB_PTR && sel == 2'h0)
      |=> ptr0 == $past(ptr0) - {6'h00, $past(lit6)})
    else $error("pointer subtract wrong");

  // push finishes in its own cycle
  chk_push_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
    (cycle_en && ext_on && !ext_busy && op_hi == xstack_pkg::OP_PUSH_LIT) |=> !ext_busy)
    else $error("push took a second cycle");

  // return forms of add and subtract, first cycle
  sequence ret_first;
    cycle_en && ext_on && !ext_busy && sel == xstack_pkg::SEL_FRAME_RET &&
    (op_hi == xstack_pkg::OP_ADD_PTR || op_hi == xstack_pkg::OP_SUB_PTR);
  endsequence

  // return loads pc from the stack top
  chk_ret_loads_top: assert property (@(posedge sys_clk) disable iff (rst)
    ret_first |-> (pc_load && pc_value == return_stack_top))
    else $error("return did not load stack top");

  // subtract form changes only the frame pointer
  chk_ret_sub_fp: assert property (@(posedge sys_clk) disable iff (rst)
    (ret_first and (op_hi == xstack_pkg::OP_SUB_PTR))
      |=> (frame_pointer == $past(frame_pointer) - {6'h00, $past(lit6)} &&
           ptr0 == $past(ptr0) && ptr1 == $past(ptr1)))
    else $error("subtract and return hit wrong pointer");

  chk_nop_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_r.seq_r == xstack_pkg::ST_NOP2) |-> (!mem_wr && !mem_rd && !pc_load && !stack_push))
    else $error("second cycle of return or call not idle");

  // call, first cycle
  sequence call_first;
    cycle_en && ext_on && !ext_busy && instr_word == xstack_pkg::OP_CALL_W;
  endsequence

  // call pushes and jumps, then idles a cycle
  chk_call_jump: assert property (@(posedge sys_clk) disable iff (rst)
    call_first |-> (stack_push && pc_load &&
                    pc_value == {pc_latch_upper, pc_latch_high, working_reg}) ##1 ext_busy)
    else $error("call via working register misbehaved");

  // literal destination taken whole from second word
  chk_move_dest_lit: assert property (@(posedge sys_clk) disable iff (rst)
    (cycle_en && cur_r.seq_r == xstack_pkg::ST_MOVE2 && !cur_r.is_ss_r &&
     instr_word[15:12] == xstack_pkg::OP_SECOND_WD)
      |-> (mem_wr && mem_addr == instr_word[11:0]))
    else $error("literal destination not written");

  // second word without the 1111 prefix writes nothing
  chk_bad_second: assert property (@(posedge sys_clk) disable iff (rst)
    (cycle_en && cur_r.seq_r == xstack_pkg::ST_MOVE2 &&
     instr_word[15:12] != xstack_pkg::OP_SECOND_WD) |-> !mem_wr)
    else $error("malformed second word wrote memory");

  // source is frame pointer plus 7-bit offset
  chk_move_src: assert property (@(posedge sys_clk) disable iff (rst)
    move_first |-> mem_addr == frame_pointer + {5'h00, instr_word[6:0]})
    else $error("indexed source address wrong");

  // busy holds until the next instruction pulse
  chk_busy_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (ext_busy && !cycle_en) |=> ext_busy)
    else $error("second cycle lost before its pulse");

endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end

module testbench;
  // one row: k high for extension ops, word, expected address, strobe, data, frame pointer
  typedef struct packed {
    logic        k;
    logic [15:0] iw;
    logic [11:0] a;
    logic        w;
    logic [7:0]  wd;
    logic [11:0] fp;
  } row_t;
  logic        sys_clk, rst, cycle_en, ext_enable, std_byte_op;
  logic [15:0] instr_word;
  logic [7:0]  working_reg, mem_rdata, pc_latch_high, mem_wdata;
  logic [3:0]  bank_select;
  logic [4:0]  pc_latch_upper;
  logic [20:0] return_stack_top, pc_current, pc_value, stack_push_val;
  logic [11:0] mem_addr, std_addr, ptr0, ptr1, frame_pointer;
  logic        mem_rd, mem_wr, std_dest_w, pc_load, stack_push, ext_busy;
  int          fail_count, compares;
  row_t        rows [15];

  extended_stack_instr_exec dut (.sys_clk, .rst, .cycle_en, .ext_enable, .instr_word,
    .std_byte_op, .working_reg, .bank_select, .pc_latch_high, .pc_latch_upper,
    .return_stack_top, .pc_current, .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .std_addr, .std_dest_w, .ptr0, .ptr1, .frame_pointer, .pc_load, .pc_value,
    .stack_push, .stack_push_val, .ext_busy);

  ////////////////////////////////////////////////////////////////////////////////
  // free-running core clock
  always #10 sys_clk = ~sys_clk;

  // present one word for one cycle; outputs settle before the rising edge
  task step(input logic [15:0] iw, input logic bo);
    @(negedge sys_clk);
    cycle_en = 1'b1;
    instr_word = iw;
    std_byte_op = bo;
    #5;
  endtask

  // gap cycle; pointers from the last edge are visible here
  task idle;
    @(negedge sys_clk);
    cycle_en = 1'b0;
    instr_word = 16'h0000;
  endtask

  // single exit of the run
  task wrap_up;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog at 1000 cycles, well beyond the fewer than 80 cycles the sequence needs
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end

  initial begin
    // frame pointer walks 000 -> 00a -> 009 -> fff -> fef across the rows
    rows = '{{1'b0, 16'h6a05, 12'h005, 1'b0, 8'h00, 12'h000},
             {1'b1, 16'he88a, 12'h000, 1'b0, 8'h00, 12'h00a},
             {1'b0, 16'h2405, 12'h00f, 1'b1, 8'h00, 12'h00a},
             {1'b0, 16'h265f, 12'h069, 1'b0, 8'h00, 12'h00a},
             {1'b0, 16'h2460, 12'h060, 1'b1, 8'h00, 12'h00a},
             {1'b0, 16'h25a0, 12'h3a0, 1'b1, 8'h00, 12'h00a},
             {1'b0, 16'h24c0, 12'hfc0, 1'b1, 8'h00, 12'h00a},
             {1'b1, 16'hea77, 12'h00a, 1'b1, 8'h77, 12'h009},
             {1'b1, 16'he98a, 12'h000, 1'b0, 8'h00, 12'hfff},
             {1'b0, 16'h2405, 12'h004, 1'b1, 8'h00, 12'hfff},
             {1'b1, 16'he805, 12'h000, 1'b0, 8'h00, 12'hfff},
             {1'b1, 16'he945, 12'h000, 1'b0, 8'h00, 12'hfff},
             {1'b1, 16'he990, 12'h000, 1'b0, 8'h00, 12'hfef},
             {1'b1, 16'he842, 12'h000, 1'b0, 8'h00, 12'hfef},
             {1'b1, 16'he901, 12'h000, 1'b0, 8'h00, 12'hfef}};
    sys_clk = 1'b0; rst = 1'b1; cycle_en = 1'b0; ext_enable = 1'b1; std_byte_op = 1'b0;
    instr_word = 16'h0000; working_reg = 8'h06; mem_rdata = 8'h00; pc_latch_high = 8'h10;
    bank_select = 4'h3; pc_latch_upper = 5'h00; return_stack_top = 21'h1abcd;
    pc_current = 21'h000200; fail_count = 0; compares = 0;
    repeat (2) @(negedge sys_clk);
    `CHK(frame_pointer, 12'h000)
    `CHK(ext_busy, 1'b0)
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    // table of single-cycle cases
    foreach (rows[i]) begin
      step(rows[i].iw, !rows[i].k);
      if (!rows[i].k) begin
        `CHK(std_addr, rows[i].a)
        `CHK(std_dest_w, rows[i].w)
      end else begin
        `CHK(mem_wr, rows[i].w)
        if (rows[i].w) begin
          `CHK(mem_addr, rows[i].a)
          `CHK(mem_wdata, rows[i].wd)
        end
      end
      idle();
      `CHK(frame_pointer, rows[i].fp)
    end
    `CHK(ptr0, 12'h004)
    `CHK(ptr1, 12'hffd)
    // indexed to file from an indirect source reads zero
    mem_rdata = 8'ha5;
    step(16'heb00, 1'b0);
    `CHK(mem_rd, 1'b0)
    `CHK(mem_addr, 12'hfef)
    idle();
    `CHK(ext_busy, 1'b1)
    step(16'hf040, 1'b0);
    `CHK(mem_addr, 12'h040)
    `CHK(mem_wdata, 8'h00)
    idle();
    // indexed to indexed, destination wraps to 000
    mem_rdata = 8'h3c;
    step(16'heb81, 1'b0);
    `CHK(mem_addr, 12'hff0)
    `CHK(mem_rd, 1'b1)
    idle();
    mem_rdata = 8'h99;
    step(16'hf011, 1'b0);
    `CHK(mem_wr, 1'b1)
    `CHK(mem_addr, 12'h000)
    `CHK(mem_wdata, 8'h3c)
    idle();
    // indirect destination, then a bad second word: no write either way
    step(16'heb81, 1'b0);
    idle();
    step(16'hf000, 1'b0);
    `CHK(mem_wr, 1'b0)
    idle();
    step(16'heb01, 1'b0);
    idle();
    step(16'he000, 1'b0);
    `CHK(mem_wr, 1'b0)
    idle();
    // subtract and return; a push offered in the idle cycle is swallowed
    step(16'he9c5, 1'b0);
    `CHK(pc_load, 1'b1)
    `CHK(pc_value, 21'h1abcd)
    idle();
    `CHK(frame_pointer, 12'hfea)
    step(16'hea11, 1'b0);
    `CHK(mem_wr, 1'b0)
    `CHK(pc_load, 1'b0)
    idle();
    `CHK(frame_pointer, 12'hfea)
    // add and return
    step(16'he8c2, 1'b0);
    `CHK(pc_load, 1'b1)
    idle();
    `CHK(frame_pointer, 12'hfec)
    step(16'h0000, 1'b0);
    idle();
    // call through the working register
    step(16'h0014, 1'b0);
    `CHK(stack_push, 1'b1)
    `CHK(stack_push_val, 21'h000202)
    `CHK(pc_value, 21'h001006)
    idle();
    step(16'h0014, 1'b0);
    `CHK(pc_load, 1'b0)
    `CHK(stack_push, 1'b0)
    idle();
    // extension off: push ignored, access bank literal again
    ext_enable = 1'b0;
    repeat (3) @(negedge sys_clk);
    step(16'hea22, 1'b0);
    `CHK(mem_wr, 1'b0)
    idle();
    `CHK(frame_pointer, 12'hfec)
    step(16'h2405, 1'b1);
    `CHK(std_addr, 12'h005)
    idle();
    // reset in the middle of a move
    ext_enable = 1'b1;
    repeat (3) @(negedge sys_clk);
    step(16'heb01, 1'b0);
    idle();
    rst = 1'b1;
    #5;
    `CHK(ext_busy, 1'b0)
    `CHK(frame_pointer, 12'h000)
    wrap_up();
  end
endmodule

`default_nettype wire
